// ===== hdl/slc_pkg.sv
// Constants for the switching line configuration block
package slc_pkg;
  localparam int REG_W = 8;
  localparam int SEL_W = 2;
  // Register select pattern [sel1, sel0] = [0,1]
  localparam logic [1:0] SEL_LINE_CONFIG = 2'h1;
  localparam logic [7:0] LINE_CONFIG_RESET = 8'h00;
  localparam int BIT_RX_FILTER = 7;
  localparam int BIT_SPARE_HI = 6;
  localparam int BIT_SINK_SOURCE = 5;
  localparam int BIT_PUSH_PULL = 4;
  localparam int BIT_SOFT_ENABLE = 3;
  localparam int BIT_LEVEL = 2;
  localparam int BIT_RX_DISABLE = 1;
  localparam int BIT_SPARE_LO = 0;
  // Filter corners in kHz, selected by the filter bit
  localparam int FILTER_SLOW_KHZ = 500;
  localparam int FILTER_FAST_KHZ = 1000;
endpackage : slc_pkg

// ===== hdl/slc_line_config.sv
// Switching line configuration register and line driver state logic
`timescale 1ns/1ps

module slc_line_config
(
  input wire logic clk_sys, // 10 MHz system clock
  input wire logic reset, // Synchronous power-up reset
  input wire logic reg_wr, // Register write strobe
  input wire logic [slc_pkg::SEL_W-1:0] reg_sel, // Register select bits
  input wire logic [slc_pkg::REG_W-1:0] reg_wdata, // Write data
  output logic [slc_pkg::REG_W-1:0] reg_rdata, // Read data
  output logic reg_hit, // Access selects this register
  input wire logic line_logic_input, // Logic-side line input pin
  input wire logic line_driver_enable_pin, // Hardware enable pin
  input wire logic switch_line_i, // Line level seen by receiver
  input wire logic aux_sense_input, // Auxiliary sense input
  output logic switch_line_o, // Line drive level
  output logic switch_line_oe, // Line output enable
  output logic line_rx_out, // Receiver logic output
  output logic aux_sense_out, // Synchronised aux sense
  output logic line_level_inverse, // Inverse of line level
  output logic filter_corner_fast_line, // Line filter 1MHz corner
  output logic filter_corner_fast_aux // Aux filter 1MHz corner
);
  import slc_pkg::*;

  // Slot of each asynchronous pin in the synchroniser bank
  localparam int PIN_LINE = 0;
  localparam int PIN_LIO = 1;
  localparam int PIN_EN = 2;
  localparam int PIN_AUX = 3;
  localparam int PIN_N = 4;

  logic [REG_W-1:0] switch_line_config_r;
  logic [PIN_N-1:0] pin_raw;
  logic [PIN_N-1:0] pin_sync;
  logic receive_filter_select;
  logic line_sink_source_select;
  logic line_push_pull;
  logic line_driver_soft_enable;
  logic level_bit;
  logic receiver_disable;
  logic driver_on;
  logic lio_s;
  logic line_s;

  assign reg_hit = (reg_sel == SEL_LINE_CONFIG);

  // Spare bits 6 and 0 are stored only, never decoded
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      switch_line_config_r <= LINE_CONFIG_RESET;
    else if (reg_wr && reg_hit)
      switch_line_config_r <= reg_wdata;
  end

  assign reg_rdata = reg_hit ? switch_line_config_r : '0;

  assign pin_raw[PIN_LINE] = switch_line_i;
  assign pin_raw[PIN_LIO] = line_logic_input;
  assign pin_raw[PIN_EN] = line_driver_enable_pin;
  assign pin_raw[PIN_AUX] = aux_sense_input;

  // Pins are asynchronous to clk_sys; only the second stage is read,
  // which costs two cycles of latency on every pin path
  genvar gi;
  generate
    for (gi = 0; gi < PIN_N; gi++)
    begin : g_pin_sync
      logic meta_r;
      logic sync_r;
      always_ff @(posedge clk_sys)
      begin
        if (reset)
        begin
          meta_r <= 1'b0;
          sync_r <= 1'b0;
        end
        else
        begin
          meta_r <= pin_raw[gi];
          sync_r <= meta_r;
        end
      end
      assign pin_sync[gi] = sync_r;
    end
  endgenerate

  assign lio_s = pin_sync[PIN_LIO];
  assign line_s = pin_sync[PIN_LINE];

  assign receive_filter_select = switch_line_config_r[BIT_RX_FILTER];
  assign line_sink_source_select = switch_line_config_r[BIT_SINK_SOURCE];
  assign line_push_pull = switch_line_config_r[BIT_PUSH_PULL];
  assign line_driver_soft_enable = switch_line_config_r[BIT_SOFT_ENABLE];
  assign level_bit = switch_line_config_r[BIT_LEVEL];
  assign receiver_disable = switch_line_config_r[BIT_RX_DISABLE];

  // One select bit feeds both analog filters
  assign filter_corner_fast_line = receive_filter_select;
  assign filter_corner_fast_aux = receive_filter_select;

  assign driver_on = line_driver_soft_enable | pin_sync[PIN_EN];

  // Level bit only counts with input high; with input low the line
  // is driven high (released in sink mode without push-pull) and the level bit is ignored.
  // Registered so the line pin never glitches on decode.
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      switch_line_o <= 1'b0;
      switch_line_oe <= 1'b0;
    end
    else if (!driver_on)
    begin
      switch_line_o <= 1'b0;
      switch_line_oe <= 1'b0;
    end
    else if (lio_s)
    begin
      switch_line_o <= level_bit;
      if (line_push_pull)
        switch_line_oe <= 1'b1;
      else if (line_sink_source_select)
        switch_line_oe <= ~level_bit;
      else
        switch_line_oe <= level_bit;
    end
    else
    begin
      // Logic input low drives the line high, except sink without push-pull, which releases it
      switch_line_o <= 1'b1;
      switch_line_oe <= line_push_pull | ~line_sink_source_select;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      line_rx_out <= 1'b1;
      line_level_inverse <= 1'b1;
      aux_sense_out <= 1'b0;
    end
    else
    begin
      line_rx_out <= receiver_disable ? 1'b1 : ~line_s;
      line_level_inverse <= ~line_s;
      aux_sense_out <= pin_sync[PIN_AUX];
    end
  end
endmodule : slc_line_config

// ===== tb/slc_load.sv
// Load model on the switching line
`timescale 1ns/1ps
module slc_load(input wire logic o, oe, pull, output logic lvl);
  assign lvl = oe ? o : pull; // Released line settles at the load pull
endmodule : slc_load

// ===== tb/slc_chk_assertions.sv
// Port checks for the line config block
`timescale 1ns/1ps
module slc_chk(input wire logic clk_sys, reset, reg_wr, reg_hit,
  input wire logic [1:0] reg_sel, input wire logic [7:0] reg_wdata,
  reg_rdata, input wire logic line_logic_input, line_driver_enable_pin,
  switch_line_i, switch_line_o, switch_line_oe, line_rx_out,
  line_level_inverse, filter_corner_fast_line, filter_corner_fast_aux);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  a_sel_hit: assert property (reg_hit == (reg_sel == 2'h1))
    else $error("select");
  a_write_back: assert property (reg_wr && reg_hit ##1 reg_hit
    |-> reg_rdata == $past(reg_wdata)) else $error("write");
  a_filter_pair: assert property (reg_hit |->
    filter_corner_fast_aux == reg_rdata[7] &&
    filter_corner_fast_line == reg_rdata[7])
    else $error("filter");
  a_rx_off: assert property (reg_hit && reg_rdata[1] |=>
    line_rx_out) else $error("rx");
  a_off_float: assert property (!line_driver_enable_pin[*3] ##0
    (reg_hit && !reg_rdata[3]) |=> !switch_line_oe) else $error("oe");
  a_pp_drive: assert property (reg_hit && reg_rdata[4:3] == 2'h3
    |=> switch_line_oe) else $error("pp");
  a_level_copy: assert property (line_logic_input[*3] ##0
    (reg_hit && reg_rdata[3]) |=> switch_line_o == $past(reg_rdata[2]))
    else $error("level");
  a_low_side: assert property (line_logic_input[*3] ##0
    (reg_hit && reg_rdata[5:3] == 3'h5)
    |=> switch_line_oe == !$past(reg_rdata[2])) else $error("sink");
  a_high_side: assert property (line_logic_input[*3] ##0
    (reg_hit && reg_rdata[5:3] == 3'h1)
    |=> switch_line_oe == $past(reg_rdata[2])) else $error("source");
  a_pin_enable: assert property (line_driver_enable_pin[*3] ##0
    (reg_hit && reg_rdata[4]) |=> switch_line_oe) else $error("enpin");
  a_inv_level: assert property (switch_line_i[*3] |=>
    !line_level_inverse) else $error("inverse");
endmodule : slc_chk
bind slc_line_config slc_chk slc_chk_inst(.*);

// ===== tb/slc_line_config_test.sv
// Bench for the line config block
`timescale 1ns/1ps
module slc_line_config_test;
  logic clk_sys = 0, reset = 1, reg_wr = 0, lli = 0, en = 0, aux = 0;
  logic [1:0] reg_sel = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  wire [7:0] rd_d;
  wire hit, lo, loe, rx, ao, inv, fl, fa, li;
  logic [7:0] cf[4] = '{8'h0C, 8'h08, 8'h2C, 8'h28};
  logic [7:0] ex[4] = '{8'h60, 8'h00, 8'h40, 8'h38};
  int miscompares = 0, check_count = 0;
  always #50 clk_sys = ~clk_sys;
  slc_line_config slc_line_config_inst(.clk_sys, .reset, .reg_wr,
    .reg_sel, .reg_wdata, .reg_rdata(rd_d), .reg_hit(hit),
    .line_logic_input(lli), .line_driver_enable_pin(en),
    .switch_line_i(li), .aux_sense_input(aux), .switch_line_o(lo),
    .switch_line_oe(loe), .line_rx_out(rx), .aux_sense_out(ao),
    .line_level_inverse(inv), .filter_corner_fast_line(fl),
    .filter_corner_fast_aux(fa));
  // Pull-up so a floating line reads differently from a driven low
  slc_load slc_load_inst(.o(lo), .oe(loe), .pull(1'b1), .lvl(li));
  task chk(input logic [7:0] got, exp);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [1:0] s, input logic [7:0] d);
    @(posedge clk_sys);
    reg_sel <= s;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [1:0] s, input logic [7:0] e);
    @(posedge clk_sys);
    reg_sel <= s;
    #1 chk(rd_d, e);
  endtask : rd
  task st(input logic [7:0] e);
    repeat (4) @(posedge clk_sys);
    #1 chk({1'b0, lo, loe, rx, inv, fl, fa, ao}, e);
  endtask : st
  task print_verdict;
    if (miscompares == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  initial
  begin
    #(500 * 100);
    miscompares++;
    print_verdict;
  end
  initial
  begin
    repeat (12) @(posedge clk_sys);
    reset <= 1'b0;
    rd(2'h1, 8'h00);
    st(8'h00);
    wr(2'h1, 8'hFF);
    rd(2'h1, 8'hFF);
    wr(2'h2, 8'h00);
    rd(2'h0, 8'h00);
    rd(2'h1, 8'hFF);
    st(8'h76);
    @(posedge clk_sys);
    lli <= 1'b1;
    wr(2'h1, 8'h18);
    st(8'h38);
    foreach (cf[i])
    begin
      wr(2'h1, cf[i]);
      st(ex[i]);
    end
    wr(2'h1, 8'h14);
    st(8'h00);
    @(posedge clk_sys);
    en <= 1'b1;
    aux <= 1'b1;
    st(8'h61);
    @(posedge clk_sys);
    lli <= 1'b0;
    aux <= 1'b0;
    wr(2'h1, 8'h10);
    st(8'h60);
    print_verdict;
  end
endmodule : slc_line_config_test
